// ### hdl/sipr_pkg.sv
// Package with register map, field positions, reset values and carriers for the ingress register bank.
package sipr_pkg;
  localparam logic [15:0] VLAN_CMD_STS_ADDR = 16'h1810;
  localparam logic [15:0] TBL_CMD_ADDR      = 16'h1811;
  localparam logic [15:0] TBL_WR_DATA_ADDR  = 16'h1812;
  localparam logic [15:0] TBL_RD_DATA_ADDR  = 16'h1813;
  localparam logic [15:0] TBL_STS_ADDR      = 16'h1814;
  localparam logic [15:0] GLOBAL_CFG_ADDR   = 16'h1840;

  localparam int PEND_BIT      = 0;
  localparam int DIR_BIT       = 7;
  localparam int ENTRY_MSB     = 5;
  localparam int PRIO_MSB      = 2;
  localparam int CFG_MSB       = 15;
  localparam int IGNORE_VID    = 15;
  localparam int TAG_PRIO_EN   = 14;
  localparam int MON_ECHO      = 13;
  localparam int SNOOP_PORT_HI = 12;
  localparam int SNOOP_PORT_LO = 10;
  localparam int IP_PRIO_EN    = 9;
  localparam int SNOOP_EN      = 7;
  localparam int CNT_TEST      = 6;
  localparam int DEST_OVERRIDE = 5;
  localparam int MCAST_FILTER  = 4;
  localparam int UCAST_FILTER  = 3;
  localparam int USE_PRECED    = 2;
  localparam int TAG_OVER_IP   = 1;
  localparam int VLAN_EN       = 0;

  localparam logic [15:0] GLOBAL_CFG_RESET = 16'h0006;
  localparam logic [7:0]  TBL_CMD_RESET    = 8'h00;
  localparam logic [2:0]  WR_DATA_RESET    = 3'h0;
  localparam logic [31:0] CNT_TEST_VALUE   = 32'h7FFF_FFFC;
  localparam logic [31:0] CNT_CLEAR_VALUE  = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_VALUE   = 32'h0000_0000;
  localparam int          TBL_DEPTH        = 64;

  typedef enum logic [1:0] {
    TBL_IDLE   = 2'b00,
    TBL_LAUNCH = 2'b01,
    TBL_EXEC   = 2'b11
  } sipr_tbl_state_t;

  typedef struct packed {
    logic        tag_valid;
    logic [2:0]  tag_prio;
    logic [11:0] tag_vid;
    logic [11:0] port_default_vlan_id;
    logic [2:0]  port_default_prio;
    logic        ip_valid;
    logic        ip_is_v4;
    logic [7:0]  tos;
    logic        dest_prio_en;
    logic [2:0]  dest_prio;
    logic        dest_found;
    logic        dest_mcast;
    logic        dest_bcast;
    logic        is_group_snoop;
    logic [2:0]  src_port_map;
    logic [2:0]  dest_port_map;
  } sipr_pkt_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  queue_prio;
    logic [11:0] vid;
    logic        vlan_rules_en;
    logic        drop;
    logic [2:0]  port_map;
  } sipr_decision_t;
endpackage

// ### hdl/sipr_regs.sv
// Register bank, priority table and ingress decision logic of the switch engine.
//
// Contract
// (R1) VLAN command status bit 0 pends while a VLAN table command runs.
// (R2) Each command register write launches one table access; a write while an access runs is ignored.
// (R3) Command bit 7 selects read (1) or write (0); resets to 0.
// (R4) Command bits 5:0 pick the table entry; bit 6 is reserved.
// (R5) Reads set table pending until fetched; host waits before reading data.
// (R6) Host loads write data before command, then polls pending.
// (R7) Write data bits 2:0 hold the priority to store; reset 000b.
// (R8) Read data bits 2:0 show fetched priority after a read; read-only.
// (R9) Table contents are not reset; host writes every entry first.
// (R10) Bit 15 ignores tag VID and uses port default VID.
// (R11) Bit 14 makes tag priority a queue choice.
// (R12) Bit 13 allows monitored packets back to their source port.
// (R13) Bits 12:10 are the snoop destination port bitmap.
// (R14) Bit 7 detects IGMP packets and forwards them to the bitmap.
// (R15) Bit 9 makes IPv4 TOS or IPv6 SC a queue choice.
// (R16) Bit 6 makes read-cleared counters load 7FFF_FFFCh instead.
// (R17) Bit 5 lets an enabled destination entry priority override all.
// (R18) Bit 4 drops unknown multicast; broadcast is exempt.
// (R19) Bit 3 drops unknown unicast destinations.
// (R20) Bit 2 picks TOS precedence (1) or table (0); resets 1.
// (R21) Bit 1 ranks tag priority above IP priority; resets 1.
// (R22) Bit 0 enables VLAN ingress rules; resets 0.
// (R23) Pending sets in the cycle after the command write.
`timescale 1ns/10ps
`default_nettype none
module sipr_regs (
  input  wire logic                    I_CORE_CLK,
  input  wire logic                    I_RESET_N,
  input  wire logic                    I_REG_WR,
  input  wire logic                    I_REG_RD,
  input  wire logic [15:0]             I_REG_ADDR,
  input  wire logic [31:0]             I_REG_WDATA,
  output logic      [31:0]             O_REG_RDATA,
  input  wire logic                    I_VLAN_CMD_START,
  input  wire logic                    I_VLAN_CMD_DONE,
  input  wire logic                    I_PKT_VALID,
  input  wire sipr_pkg::sipr_pkt_t     I_PKT,
  output sipr_pkg::sipr_decision_t     O_DECISION,
  output logic      [31:0]             O_COUNTER_READ_LOAD
);
  import sipr_pkg::*;

  // Register state.
  logic [15:0]     global_cfg;
  logic [15:0]     next_global_cfg;
  logic [7:0]      tbl_cmd;
  logic [7:0]      next_tbl_cmd;
  logic [2:0]      wr_data;
  logic [2:0]      next_wr_data;
  logic [2:0]      rd_data;
  logic [2:0]      next_rd_data;
  logic            vlan_pend;
  logic            next_vlan_pend;
  logic [31:0]     rdata;
  logic [31:0]     next_rdata;
  sipr_tbl_state_t tbl_state;
  sipr_tbl_state_t next_tbl_state;
  logic            tbl_pend;
  logic            tbl_we;
  logic            cmd_write;

  // Priority table, deliberately left without reset.
  logic [2:0]      prio_table [TBL_DEPTH];

  // Decision pipeline.
  sipr_decision_t  decision;
  sipr_decision_t  next_decision;

  // Per-port masks that keep a packet off its own source port.
  localparam int   NUM_PORTS = 3;
  logic [2:0]      fwd_mask;
  logic [2:0]      echo_mask;

  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  // A one-bit status flag in bit 0 of an otherwise zero word.
  function automatic logic [31:0] status_word(input logic flag);
    status_word = {31'h0000_0000, flag};
  endfunction

  // A three-bit priority field in the low bits of an otherwise zero word.
  function automatic logic [31:0] prio_word(input logic [2:0] prio);
    prio_word = {29'h0000_0000, prio};
  endfunction

  // The status flag is the sequencer being away from idle, so it rises the cycle after the write.
  assign tbl_pend  = (tbl_state != TBL_IDLE);
  assign cmd_write = I_REG_WR && addr_hit(I_REG_ADDR, TBL_CMD_ADDR) && !tbl_pend;

  // A port bit is cleared when the packet came in on that port; echo lifts this for snooped packets.
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port_mask
    assign fwd_mask[p]  = !I_PKT.src_port_map[p];                                 // [R12]
    assign echo_mask[p] = global_cfg[MON_ECHO] || !I_PKT.src_port_map[p];         // [R12]
  end

  // Register writes. A command write while a table access runs is ignored.
  always_comb
  begin
    next_global_cfg = global_cfg;
    next_tbl_cmd    = tbl_cmd;
    next_wr_data    = wr_data;
    if (I_REG_WR && addr_hit(I_REG_ADDR, GLOBAL_CFG_ADDR))
    begin
      next_global_cfg = I_REG_WDATA[CFG_MSB:0];                                    // [R10] [R22]
    end
    if (cmd_write)
    begin
      next_tbl_cmd = {I_REG_WDATA[DIR_BIT], 1'b0, I_REG_WDATA[ENTRY_MSB:0]};        // [R3] [R4]
    end
    if (I_REG_WR && addr_hit(I_REG_ADDR, TBL_WR_DATA_ADDR))
    begin
      next_wr_data = I_REG_WDATA[PRIO_MSB:0];                                      // [R7]
    end
  end

  // Host-visible configuration registers.
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESET_N)
    begin
      global_cfg <= GLOBAL_CFG_RESET;                                              // [R20] [R21] [R22]
      tbl_cmd    <= TBL_CMD_RESET;                                                 // [R3]
      wr_data    <= WR_DATA_RESET;                                                 // [R7]
    end
    else
    begin
      global_cfg <= next_global_cfg;
      tbl_cmd    <= next_tbl_cmd;
      wr_data    <= next_wr_data;
    end
  end

  // VLAN command pending flag; a start in the same cycle as a done keeps it set.
  always_comb
  begin
    next_vlan_pend = vlan_pend;
    if (I_VLAN_CMD_DONE)
    begin
      next_vlan_pend = 1'b0;
    end
    if (I_VLAN_CMD_START)
    begin
      next_vlan_pend = 1'b1;                                                       // [R1]
    end
  end

  // VLAN command pending flag register.
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESET_N)
    begin
      vlan_pend <= 1'b0;
    end
    else
    begin
      vlan_pend <= next_vlan_pend;
    end
  end

  // Table access timing, counted from the edge that takes the command write:
  // at that edge the sequencer leaves idle and the status flag reads 1,
  // the next edge moves it to execute, and the edge after that writes the entry
  // or captures the read data and returns to idle, when the flag reads 0 again.
  // A host that polls the status register right after the write never sees a stale 0.
  // Table access sequencer: launch, execute, return to idle.
  always_comb
  begin
    next_tbl_state = tbl_state;
    next_rd_data   = rd_data;
    tbl_we         = 1'b0;
    case (tbl_state)
      TBL_IDLE:
      begin
        if (cmd_write)
        begin
          next_tbl_state = TBL_LAUNCH;                                             // [R2] [R23]
        end
      end
      TBL_LAUNCH:
      begin
        next_tbl_state = TBL_EXEC;
      end
      TBL_EXEC:
      begin
        if (tbl_cmd[DIR_BIT])
        begin
          next_rd_data = prio_table[tbl_cmd[ENTRY_MSB:0]];                         // [R5] [R8]
        end
        else
        begin
          tbl_we = 1'b1;                                                           // [R6]
        end
        next_tbl_state = TBL_IDLE;
      end
      default:
      begin
        next_tbl_state = TBL_IDLE;
      end
    endcase
  end

  // Sequencer state and the entry captured by a table read.
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESET_N)
    begin
      tbl_state <= TBL_IDLE;
      rd_data   <= WR_DATA_RESET;
    end
    else
    begin
      tbl_state <= next_tbl_state;
      rd_data   <= next_rd_data;
    end
  end

  // Register read mux; unmapped addresses read as zero.
  // A read in the same cycle as a write returns the value from before the write.
  always_comb
  begin
    next_rdata = rdata;
    if (I_REG_RD)
    begin
      case (I_REG_ADDR)
        VLAN_CMD_STS_ADDR:
        begin
          next_rdata = status_word(vlan_pend);                                     // [R1]
        end
        TBL_CMD_ADDR:
        begin
          next_rdata = {24'h00_0000, tbl_cmd};
        end
        TBL_WR_DATA_ADDR:
        begin
          next_rdata = prio_word(wr_data);
        end
        TBL_RD_DATA_ADDR:
        begin
          next_rdata = prio_word(rd_data);                                         // [R8]
        end
        TBL_STS_ADDR:
        begin
          next_rdata = status_word(tbl_pend);                                      // [R5]
        end
        GLOBAL_CFG_ADDR:
        begin
          next_rdata = {16'h0000, global_cfg};
        end
        default:
        begin
          next_rdata = UNMAPPED_VALUE;
        end
      endcase
    end
  end

  // Read data register; it holds the last value read until the next read.
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESET_N)
    begin
      rdata <= UNMAPPED_VALUE;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // Ingress decision for one packet, registered one cycle later.
  always_comb
  begin
    logic [2:0] ip_prio;
    logic       tag_ok;
    logic       ip_ok;
    logic       unknown_mcast;
    logic       unknown_ucast;
    logic [2:0] ports;
    ip_prio       = 3'h0;
    tag_ok        = 1'b0;
    ip_ok         = 1'b0;
    unknown_mcast = 1'b0;
    unknown_ucast = 1'b0;
    ports         = 3'h0;
    next_decision = '0;
    next_decision.valid = I_PKT_VALID;

    if (I_PKT.ip_is_v4 && global_cfg[USE_PRECED])
    begin
      ip_prio = I_PKT.tos[7:5];                                                    // [R20]
    end
    else
    begin
      ip_prio = prio_table[I_PKT.tos[7:2]];                                        // [R20]
    end
    tag_ok = global_cfg[TAG_PRIO_EN] && I_PKT.tag_valid;                           // [R11]
    ip_ok  = global_cfg[IP_PRIO_EN] && I_PKT.ip_valid;                             // [R15]

    // Sources in falling rank: an enabled destination entry, then tag or IP priority as
    // ranked by the tag-over-IP bit, then the port default. IPv6 packets always use the
    // table because they carry no precedence field.
    if (global_cfg[DEST_OVERRIDE] && I_PKT.dest_prio_en)
    begin
      next_decision.queue_prio = I_PKT.dest_prio;                                  // [R17]
    end
    else if (tag_ok && (global_cfg[TAG_OVER_IP] || !ip_ok))
    begin
      next_decision.queue_prio = I_PKT.tag_prio;                                   // [R21]
    end
    else if (ip_ok)
    begin
      next_decision.queue_prio = ip_prio;
    end
    else
    begin
      next_decision.queue_prio = I_PKT.port_default_prio;
    end

    next_decision.vlan_rules_en = global_cfg[VLAN_EN];                             // [R22]
    if (global_cfg[IGNORE_VID] || !I_PKT.tag_valid)
    begin
      next_decision.vid = I_PKT.port_default_vlan_id;                              // [R10]
    end
    else
    begin
      next_decision.vid = I_PKT.tag_vid;
    end

    unknown_mcast = I_PKT.dest_mcast && !I_PKT.dest_bcast && !I_PKT.dest_found;
    unknown_ucast = !I_PKT.dest_mcast && !I_PKT.dest_bcast && !I_PKT.dest_found;

    if (global_cfg[SNOOP_EN] && I_PKT.is_group_snoop)
    begin
      ports = global_cfg[SNOOP_PORT_HI:SNOOP_PORT_LO] & echo_mask;                 // [R12] [R13] [R14]
    end
    else
    begin
      ports = I_PKT.dest_port_map & fwd_mask;                                      // [R12]
      next_decision.drop = (global_cfg[MCAST_FILTER] && unknown_mcast)             // [R18]
                         || (global_cfg[UCAST_FILTER] && unknown_ucast);           // [R19]
    end
    next_decision.port_map = next_decision.drop ? 3'h0 : ports;
  end

  // Decision register; it stands for one cycle and is recomputed at every edge.
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESET_N)
    begin
      decision <= '0;
    end
    else
    begin
      decision <= next_decision;
    end
  end

  // The table keeps whatever it held across reset.
  always_ff @(posedge I_CORE_CLK)
  begin
    if (tbl_we)
    begin
      prio_table[tbl_cmd[ENTRY_MSB:0]] <= wr_data;                                 // [R9]
    end
  end

  assign O_REG_RDATA         = rdata;
  assign O_DECISION          = decision;
  assign O_COUNTER_READ_LOAD = global_cfg[CNT_TEST] ? CNT_TEST_VALUE : CNT_CLEAR_VALUE;  // [R16]
endmodule
`default_nettype wire

// ### test/sipr_regs_checker.sv
// Concurrent checks on the ports of the ingress register bank.
`timescale 1ns/10ps
`default_nettype none
module sipr_regs_checker (
  input wire logic                 I_CORE_CLK,
  input wire logic                 I_RESET_N,
  input wire logic                 I_REG_WR,
  input wire logic                 I_REG_RD,
  input wire logic [15:0]          I_REG_ADDR,
  input wire logic [31:0]          I_REG_WDATA,
  input wire logic [31:0]          O_REG_RDATA,
  input wire logic                 I_VLAN_CMD_START,
  input wire logic                 I_VLAN_CMD_DONE,
  input wire logic                 I_PKT_VALID,
  input wire sipr_pkg::sipr_pkt_t  I_PKT,
  input wire sipr_pkg::sipr_decision_t O_DECISION,
  input wire logic [31:0]          O_COUNTER_READ_LOAD
);
  import sipr_pkg::*;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);
  sequence s_wr(logic [15:0] a); I_REG_WR && I_REG_ADDR == a; endsequence
  sequence s_rd(logic [15:0] a); I_REG_RD && !I_REG_WR && I_REG_ADDR == a; endsequence
  a_tbl_pend_set: assert property (s_wr(TBL_CMD_ADDR) ##1 s_rd(TBL_STS_ADDR) |=> O_REG_RDATA == 32'h0000_0001)
    else $error("table pending not seen right after command write");
  a_vlan_pend_set: assert property (I_VLAN_CMD_START ##1 s_rd(VLAN_CMD_STS_ADDR) |=> O_REG_RDATA == 32'h0000_0001)
    else $error("vlan pending not set after start");
  a_unmapped_zero: assert property (I_REG_RD && !(I_REG_ADDR inside {[16'h1810:16'h1814], 16'h1840})
    |=> O_REG_RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rd_field_only: assert property (s_rd(TBL_RD_DATA_ADDR) |=> O_REG_RDATA[31:3] == 29'h0)
    else $error("read data reserved bits set");
  a_rdata_hold: assert property ($past(I_RESET_N) && !$past(I_REG_RD) |-> $stable(O_REG_RDATA))
    else $error("read data changed without a read");
  a_cnt_load_value: assert property (s_rd(GLOBAL_CFG_ADDR) |=>
    O_COUNTER_READ_LOAD == (O_REG_RDATA[CNT_TEST] ? CNT_TEST_VALUE : CNT_CLEAR_VALUE))
    else $error("counter load value disagrees with config");
  a_drop_no_ports: assert property (O_DECISION.drop |-> O_DECISION.port_map == 3'h0)
    else $error("dropped packet has ports");
  a_cfg_readback: assert property (s_wr(GLOBAL_CFG_ADDR) ##1 !I_REG_WR ##1 s_rd(GLOBAL_CFG_ADDR)
    |=> O_REG_RDATA == ($past(I_REG_WDATA, 3) & 32'h0000_FFFF))
    else $error("config readback wrong");
  a_wr_data_back: assert property (s_wr(TBL_WR_DATA_ADDR) ##1 !I_REG_WR ##1 s_rd(TBL_WR_DATA_ADDR)
    |=> O_REG_RDATA == ($past(I_REG_WDATA, 3) & 32'h0000_0007))
    else $error("write data readback wrong");
endmodule
bind sipr_regs sipr_regs_checker sipr_regs_checker_inst (.I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N),
  .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
  .O_REG_RDATA(O_REG_RDATA), .I_VLAN_CMD_START(I_VLAN_CMD_START), .I_VLAN_CMD_DONE(I_VLAN_CMD_DONE),
  .I_PKT_VALID(I_PKT_VALID), .I_PKT(I_PKT), .O_DECISION(O_DECISION), .O_COUNTER_READ_LOAD(O_COUNTER_READ_LOAD));
`default_nettype wire

// ### test/sipr_host_model.sv
// Host model that reaches the register bank with one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
module sipr_host_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_rdata,
  output logic             o_wr,
  output logic             o_rd,
  output logic [15:0]      o_addr,
  output logic [31:0]      o_wdata
);
  import sipr_pkg::*;
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 32'h0000_0000;
  end
  // Tasks are entered just after a falling edge and end after one idle cycle, so no line
  // is set twice at one instant; released lines show the inverse value.
  task automatic write(input logic [15:0] a, input logic [31:0] d);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    @(negedge i_clk);
  endtask
  task automatic read(input logic [15:0] a, output logic [31:0] d);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    d = i_rdata;
    o_rd = 1'b0;
    o_addr = ~a;
    @(negedge i_clk);
  endtask
  // Issues a table command and polls from the very next cycle until the pending flag clears.
  task automatic tbl_cmd(input logic [31:0] c, output int polls);
    logic [31:0] s;
    o_wr = 1'b1;
    o_addr = TBL_CMD_ADDR;
    o_wdata = c;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~c;
    polls = 0;
    do
    begin
      read(TBL_STS_ADDR, s);
      polls++;
    end while (s[PEND_BIT] !== 1'b0 && polls < 16);
  endtask
endmodule
`default_nettype wire

// ### test/switch_ingress_priority_regs_test.sv
// Self-checking bench for the ingress register bank.
`timescale 1ns/10ps
`default_nettype none
module switch_ingress_priority_regs_test;
  import sipr_pkg::*;
  logic           core_clk, reset_n, reg_wr, reg_rd, cmd_start, cmd_done, pkt_valid;
  logic [15:0]    reg_addr, cfg;
  logic [31:0]    reg_wdata, reg_rdata, cnt_load, rd;
  logic [5:0]     idx;
  logic [2:0]     tbl [64];
  sipr_pkt_t      pkt;
  sipr_decision_t dec;
  int             seed = 57, bad_count = 0, n_compared = 0, cycles = 0, i, polls;
  localparam logic [15:0] ADDRS [7] = '{16'h1810, 16'h1811, 16'h1812, 16'h1813, 16'h1814, 16'h1840, 16'h1815};
  localparam logic [31:0] RSTV [7] = '{0, 0, 0, 0, 0, 32'h0000_0006, 0};

  sipr_regs sipr_regs_inst (.I_CORE_CLK(core_clk), .I_RESET_N(reset_n), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
    .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .O_REG_RDATA(reg_rdata), .I_VLAN_CMD_START(cmd_start),
    .I_VLAN_CMD_DONE(cmd_done), .I_PKT_VALID(pkt_valid), .I_PKT(pkt), .O_DECISION(dec), .O_COUNTER_READ_LOAD(cnt_load));
  sipr_host_model sipr_host_model_inst (.i_clk(core_clk), .i_rdata(reg_rdata), .o_wr(reg_wr), .o_rd(reg_rd),
    .o_addr(reg_addr), .o_wdata(reg_wdata));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    sipr_host_model_inst.read(a, rd);
    check($sformatf("reg %h", a), rd, exp);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Packs valid, priority, vid, rules enable, drop and port map as the decision carrier does.
  function automatic logic [31:0] exp_dec(input logic [15:0] c, input sipr_pkt_t p);
    logic tag_ok, ip_ok, drop;
    logic [2:0] pr, pm;
    tag_ok = c[TAG_PRIO_EN] & p.tag_valid;
    ip_ok = c[IP_PRIO_EN] & p.ip_valid;
    pr = (p.ip_is_v4 && c[USE_PRECED]) ? p.tos[7:5] : tbl[p.tos[7:2]];
    pr = (tag_ok && (c[TAG_OVER_IP] || !ip_ok)) ? p.tag_prio : ip_ok ? pr : p.port_default_prio;
    if (c[DEST_OVERRIDE] && p.dest_prio_en)
      pr = p.dest_prio;
    drop = !(c[SNOOP_EN] && p.is_group_snoop) && !p.dest_found && !p.dest_bcast
      && (p.dest_mcast ? c[MCAST_FILTER] : c[UCAST_FILTER]);
    if (c[SNOOP_EN] && p.is_group_snoop)
      pm = c[SNOOP_PORT_HI:SNOOP_PORT_LO] & ~(c[MON_ECHO] ? 3'b000 : p.src_port_map);
    else
      pm = drop ? 3'b000 : p.dest_port_map & ~p.src_port_map;
    return {11'h0, 1'b1, pr, (c[IGNORE_VID] || !p.tag_valid) ? p.port_default_vlan_id : p.tag_vid,
      c[VLAN_EN], drop, pm};
  endfunction

  initial
  begin
    reset_n = 1'b0;
    cmd_start = 1'b0;
    cmd_done = 1'b0;
    pkt_valid = 1'b0;
    pkt = '0;
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    for (i = 0; i < 7; i++)
      rdchk(ADDRS[i], RSTV[i]);
    $display("test reset values done");
    for (i = 0; i < 64; i++)
    begin
      tbl[i] = 3'($random(seed));
      sipr_host_model_inst.write(TBL_WR_DATA_ADDR, {29'($random(seed)), tbl[i]});
      sipr_host_model_inst.tbl_cmd({24'($random(seed)), 2'b00, 6'(i)}, polls);
      check("write polls", 32'(polls), 2);
    end
    rdchk(TBL_WR_DATA_ADDR, {29'h0, tbl[63]});
    rd = $random(seed);
    sipr_host_model_inst.write(TBL_WR_DATA_ADDR, rd);
    rdchk(TBL_WR_DATA_ADDR, {29'h0, rd[2:0]});
    for (i = 0; i < 24; i++)
    begin
      idx = (i == 0) ? 6'h3F : 6'($random(seed));
      sipr_host_model_inst.tbl_cmd({24'($random(seed)), 2'b11, idx}, polls);
      check("read polls", 32'(polls), 2);
      rdchk(TBL_RD_DATA_ADDR, {29'h0, tbl[idx]});
      rdchk(TBL_CMD_ADDR, {24'h0, 2'b10, idx});
    end
    $display("test priority table done");
    cmd_start = 1'b1;
    @(negedge core_clk);
    cmd_start = 1'b0;
    rdchk(VLAN_CMD_STS_ADDR, 1);
    cmd_done = 1'b1;
    @(negedge core_clk);
    cmd_done = 1'b0;
    rdchk(VLAN_CMD_STS_ADDR, 0);
    $display("test vlan pending done");
    for (i = 0; i < 400; i++)
    begin
      if (i % 25 == 0)
      begin
        cfg = (i == 0) ? 16'hFFFF : 16'($random(seed));
        sipr_host_model_inst.write(GLOBAL_CFG_ADDR, {16'($random(seed)), cfg});
        rdchk(GLOBAL_CFG_ADDR, {16'h0, cfg});
        check("counter load", cnt_load, cfg[CNT_TEST] ? CNT_TEST_VALUE : CNT_CLEAR_VALUE);
      end
      pkt = 55'({$random(seed), $random(seed)});
      pkt_valid = 1'b1;
      @(negedge core_clk);
      check("decision", 32'(dec), exp_dec(cfg, pkt));
    end
    pkt_valid = 1'b0;
    $display("test ingress decisions done");
    summarize();
  end
endmodule
`default_nettype wire
